// ---- hdl/pldh_pkg.sv ----
// Constants and types for the lock-detect and holdover controller
// Contract
// - Lock asserts only after a programmed count of consecutive in-window cycles.
// - Lock holds until one cycle exceeds the wider unlock threshold.
// - Window timing comes from window bit, antibacklash width, lock counter; the code takes the window from the first two only.
// - Lock pin, status pin and monitor pin muxes can each select lock.
// - Current-source code sources while locked, grounds at once when unlocked.
// - Pin comparator selectable at monitor and status pins, both polarities.
// - Holdover puts the charge pump output into high impedance.
// - Both enable bits needed; otherwise manual and automatic holdover are off.
// - Manual mode: falling sync edge enters holdover; edge, not level.
// - Leave holdover only at next reference edge after sync high.
// - Leaving holdover resets the B counter that cycle, prescaler untouched.
// - Automatic mode enters holdover when sensed lock pin shows loss.
// - Comparator enable bit; when disabled lock pin is sensed as high.
// - No re-entry until lock regained and lock pin charged again.
// - Holdover follows the selected reference; switchover loss lasts one edge.
// - Lock detect disable bit at zero enables it; keep zero for auto.
// - External holdover bit: zero automatic, one manual via sync pin.
// - Counter code 00b means five cycles; window bit 0b means high range.
package pldh_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CP_STAT = 8'h17;
  localparam logic [7:0] IDX_LOCK_CFG = 8'h18;
  localparam logic [7:0] IDX_LD_CTRL = 8'h1A;
  localparam logic [7:0] IDX_MON_CTRL = 8'h1B;
  localparam logic [7:0] IDX_HOLD_CFG = 8'h1D;
  localparam logic [7:0] IDX_LOCK_STAT = 8'h20;
  // Field positions
  localparam int ABP_LSB = 0;
  localparam int STAT_SEL_LSB = 2;
  localparam int LC_DIS_BIT = 3;
  localparam int LC_WIN_BIT = 4;
  localparam int LC_CNT_LSB = 5;
  localparam int HC_EN_A_BIT = 0;
  localparam int HC_EXT_BIT = 1;
  localparam int HC_EN_B_BIT = 2;
  localparam int HC_CMP_BIT = 3;
  // Reset values
  localparam logic [7:0] RST_CP_STAT = 8'h00;
  localparam logic [7:0] RST_LOCK_CFG = 8'h00;
  localparam logic [5:0] RST_LD_CTRL = 6'h00;
  localparam logic [4:0] RST_MON_CTRL = 5'h00;
  localparam logic [3:0] RST_HOLD_CFG = 4'h0;
  // Pin mux codes
  localparam logic [5:0] LD_SEL_LOW = 6'h00;
  localparam logic [5:0] LD_SEL_DLD = 6'h01;
  localparam logic [5:0] LD_SEL_CSRC = 6'h04;
  localparam logic [5:0] PIN_SEL_LOW = 6'h00;
  localparam logic [5:0] PIN_SEL_DLD = 6'h01;
  localparam logic [5:0] PIN_SEL_CMP = 6'h02;
  localparam logic [5:0] PIN_SEL_CMP_N = 6'h03;
  // Consecutive in-window cycles per counter code
  localparam logic [7:0] LOCK_CNT_C0 = 8'h05;
  localparam logic [7:0] LOCK_CNT_C1 = 8'h10;
  localparam logic [7:0] LOCK_CNT_C2 = 8'h40;
  localparam logic [7:0] LOCK_CNT_C3 = 8'hFF;
  // Window timing in ns and in ref_clk cycles
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOCK_WIN_HI_NS = 16;
  localparam int LOCK_WIN_LO_NS = 8;
  localparam int ABP_STEP_NS = 4;
  localparam int UNLOCK_MARGIN_NS = 8;
  localparam logic [7:0] LOCK_WIN_HI_CYC = 8'(LOCK_WIN_HI_NS / CLK_PERIOD_NS);
  localparam logic [7:0] LOCK_WIN_LO_CYC = 8'(LOCK_WIN_LO_NS / CLK_PERIOD_NS);
  localparam logic [7:0] ABP_STEP_CYC = 8'(ABP_STEP_NS / CLK_PERIOD_NS);
  localparam logic [7:0] UNLOCK_MARGIN_CYC =
    8'(UNLOCK_MARGIN_NS / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    HO_ARMED = 3'b001,
    HO_HOLD = 3'b010,
    HO_REARM = 3'b100
  } pldh_ho_e;
endpackage

// ---- hdl/pldh_ld_if.sv ----
// Bundle between the controller and its digital lock detector
interface pldh_ld_if;
  logic enable;
  logic ref_rise;
  logic fb_rise;
  logic [7:0] lock_thr;
  logic [7:0] unlock_thr;
  logic [7:0] need_cnt;
  logic digital_lock_flag;
  modport det(input enable, ref_rise, fb_rise, lock_thr, unlock_thr,
              need_cnt, output digital_lock_flag);
  modport ctl(output enable, ref_rise, fb_rise, lock_thr, unlock_thr,
              need_cnt, input digital_lock_flag);
endinterface

// ---- hdl/pldh_sync.sv ----
// Two-flop synchronisers with edge detection, one per input bit
module pldh_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q, sync_q, prev_q;
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        meta_q[i] <= RST_VAL[i];
        sync_q[i] <= RST_VAL[i];
        prev_q[i] <= RST_VAL[i];
      end else begin
        meta_q[i] <= din[i];
        sync_q[i] <= meta_q[i];
        prev_q[i] <= sync_q[i];
      end
    end
    assign level[i] = sync_q[i];
    assign rise[i] = sync_q[i] & ~prev_q[i];
    assign fall[i] = ~sync_q[i] & prev_q[i];
  end
endmodule

// ---- hdl/pldh_lock_det.sv ----
// Digital lock detector measuring edge spacing at the phase detector
module pldh_lock_det
  import pldh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  pldh_ld_if.det lb
);
  logic open_q, dld_q, eval;
  logic [7:0] cnt_q, good_q, diff;
  logic [8:0] good_nx;
  logic any_edge, both_edge;

  assign any_edge = lb.ref_rise | lb.fb_rise;
  assign both_edge = lb.ref_rise & lb.fb_rise;
  assign good_nx = {1'b0, good_q} + 9'h001;

  // Any edge closes an open gap; a gap past unlock closes on its own
  always_comb begin
    eval = 1'b0;
    diff = cnt_q;
    if (open_q && (any_edge || cnt_q > lb.unlock_thr)) begin
      eval = 1'b1;
    end else if (!open_q && both_edge) begin
      eval = 1'b1;
      diff = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      open_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (!lb.enable) begin
      open_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (open_q) begin
      if (eval) begin
        open_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end else if (any_edge && !both_edge) begin
      open_q <= 1'b1;
      cnt_q <= 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dld_q <= 1'b0;
      good_q <= 8'h00;
    end else if (!lb.enable) begin
      dld_q <= 1'b0;
      good_q <= 8'h00;
    end else if (eval) begin
      if (diff > lb.unlock_thr) begin
        dld_q <= 1'b0;
        good_q <= 8'h00;
      end else if (diff < lb.lock_thr) begin
        if (good_q != 8'hFF) begin
          good_q <= good_nx[7:0];
        end
        if (good_nx >= {1'b0, lb.need_cnt}) begin
          dld_q <= 1'b1;
        end
      end else begin
        // Hysteresis band: lock kept, run broken
        good_q <= 8'h00;
      end
    end
  end

  assign lb.digital_lock_flag = dld_q;
endmodule

// ---- hdl/pldh_core.sv ----
// Lock-detect pin muxing and holdover control with APB registers
module pldh_core
  import pldh_pkg::*;
#(
  parameter int CHARGE_CYC = 64
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_pfd_in,
  input wire logic fb_pfd_in,
  input wire logic sync_b,
  output logic lock_detect_pin_o,
  output logic lock_detect_pin_oe,
  output logic status_pin,
  output logic reference_monitor_pin,
  output logic cp_hiz,
  output logic b_counter_reset
);
  // Register bank
  logic [7:0] cp_stat_q, lock_cfg_q;
  logic [5:0] ld_ctrl_q;
  logic [4:0] mon_ctrl_q;
  logic [3:0] hold_cfg_q;
  // Bus side
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rd_val;
  logic [7:0] idx;
  logic hit, setup, wr_take;
  // Pins and holdover
  logic [2:0] lvl, rise, fall;
  logic ref_rise, fb_rise, sync_hi, sync_fall;
  logic digital_lock_flag, csrc, ld_level, sensed_ld, cmp_en;
  logic hold_en, manual;
  logic [15:0] charge_cnt_q;
  logic charge_done_q;
  logic ld_o_q, ld_oe_q, status_q, reference_monitor_pin_q, cp_hiz_q, bres_q, bres_d;
  logic [7:0] base_thr, lock_thr;
  pldh_ho_e st_q, st_d;

  // Sync idles high so reset does not fake a falling edge
  pldh_sync #(.W(3), .RST_VAL(3'b100)) u_sync (
    .clk(ref_clk),
    .rst_b(rst_b),
    .din({sync_b, fb_pfd_in, ref_pfd_in}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );
  assign ref_rise = rise[0];
  assign fb_rise = rise[1];
  assign sync_hi = lvl[2];
  assign sync_fall = fall[2];

  // APB slave: zero wait states, error on unmapped index
  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign wr_take = psel & penable & pready_q & pwrite & hit;

  always_comb begin
    hit = paddr[1:0] == 2'h0;
    rd_val = 32'h0000_0000;
    unique case (idx)
      IDX_CP_STAT: rd_val[7:0] = cp_stat_q;
      IDX_LOCK_CFG: rd_val[7:0] = lock_cfg_q;
      IDX_LD_CTRL: rd_val[5:0] = ld_ctrl_q;
      IDX_MON_CTRL: rd_val[4:0] = mon_ctrl_q;
      IDX_HOLD_CFG: rd_val[3:0] = hold_cfg_q;
      IDX_LOCK_STAT: rd_val[3:0] = {cp_hiz_q, charge_done_q, sensed_ld, digital_lock_flag};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      prdata_q <= (setup && !pwrite && hit) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cp_stat_q <= RST_CP_STAT;
      lock_cfg_q <= RST_LOCK_CFG;
      ld_ctrl_q <= RST_LD_CTRL;
      mon_ctrl_q <= RST_MON_CTRL;
      hold_cfg_q <= RST_HOLD_CFG;
    end else if (wr_take) begin
      unique case (idx)
        IDX_CP_STAT: cp_stat_q <= pwdata[7:0];
        IDX_LOCK_CFG: lock_cfg_q <= pwdata[7:0];
        IDX_LD_CTRL: ld_ctrl_q <= pwdata[5:0];
        IDX_MON_CTRL: mon_ctrl_q <= pwdata[4:0];
        IDX_HOLD_CFG: hold_cfg_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // window from window bit and antibacklash; the counter only sets need_cnt
  always_comb begin
    // window bit 0 picks the high range
    base_thr = lock_cfg_q[LC_WIN_BIT] ? LOCK_WIN_LO_CYC : LOCK_WIN_HI_CYC;
    lock_thr = 8'(base_thr + ABP_STEP_CYC * {6'h00, cp_stat_q[ABP_LSB +: 2]});
  end

  pldh_ld_if ld_bus ();
  // detector runs only while its disable bit is clear
  assign ld_bus.enable = ~lock_cfg_q[LC_DIS_BIT];
  assign ld_bus.ref_rise = ref_rise;
  assign ld_bus.fb_rise = fb_rise;
  assign ld_bus.lock_thr = lock_thr;
  // unlock threshold sits wider than lock
  assign ld_bus.unlock_thr = 8'(lock_thr + UNLOCK_MARGIN_CYC);
  always_comb begin
    unique case (lock_cfg_q[LC_CNT_LSB +: 2])
      2'h0: ld_bus.need_cnt = LOCK_CNT_C0;
      2'h1: ld_bus.need_cnt = LOCK_CNT_C1;
      2'h2: ld_bus.need_cnt = LOCK_CNT_C2;
      default: ld_bus.need_cnt = LOCK_CNT_C3;
    endcase
  end
  assign digital_lock_flag = ld_bus.digital_lock_flag;

  pldh_lock_det u_lock_det (
    .clk(ref_clk),
    .rst_b(rst_b),
    .lb(ld_bus.det)
  );

  // capacitor charge as a counter, dumped on any unlocked cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      charge_cnt_q <= 16'h0000;
      charge_done_q <= 1'b0;
    end else if (!digital_lock_flag) begin
      charge_cnt_q <= 16'h0000;
      charge_done_q <= 1'b0;
    end else if (charge_cnt_q == 16'(CHARGE_CYC - 1)) begin
      charge_done_q <= 1'b1;
    end else begin
      charge_cnt_q <= charge_cnt_q + 16'h0001;
    end
  end

  // Comparator sees the pin level; in current-source mode the cap
  assign csrc = ld_ctrl_q == LD_SEL_CSRC;
  assign ld_level = csrc ? charge_done_q : (ld_oe_q & ld_o_q);
  assign cmp_en = hold_cfg_q[HC_CMP_BIT];
  assign sensed_ld = cmp_en ? ld_level : 1'b1;

  function automatic logic pin_mux(input logic [5:0] code, input logic lk,
                                   input logic cmp);
    unique case (code)
      PIN_SEL_DLD: pin_mux = lk;
      PIN_SEL_CMP: pin_mux = cmp;
      PIN_SEL_CMP_N: pin_mux = ~cmp;
      default: pin_mux = 1'b0;
    endcase
  endfunction

  // each pin has its own selector
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ld_o_q <= 1'b0;
      ld_oe_q <= 1'b1;
    end else begin
      unique case (ld_ctrl_q)
        LD_SEL_LOW: begin
          ld_o_q <= 1'b0;
          ld_oe_q <= 1'b1;
        end
        // source while locked, ground at once otherwise
        LD_SEL_DLD, LD_SEL_CSRC: begin
          ld_o_q <= digital_lock_flag;
          ld_oe_q <= 1'b1;
        end
        default: begin
          ld_o_q <= 1'b0;
          ld_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // comparator at status and monitor pins, both senses
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= 1'b0;
      reference_monitor_pin_q <= 1'b0;
    end else begin
      status_q <= pin_mux(cp_stat_q[STAT_SEL_LSB +: 6], digital_lock_flag, ld_level);
      reference_monitor_pin_q <= pin_mux({1'b0, mon_ctrl_q}, digital_lock_flag, ld_level);
    end
  end

  // both enable bits must be set
  assign hold_en = hold_cfg_q[HC_EN_A_BIT] & hold_cfg_q[HC_EN_B_BIT];
  assign manual = hold_cfg_q[HC_EXT_BIT];

  // Reference input is whichever reference is selected upstream
  always_comb begin
    st_d = st_q;
    bres_d = 1'b0;
    if (!hold_en) begin
      st_d = HO_REARM;
    end else begin
      unique case (st_q)
        HO_ARMED: begin
          // manual entry on the sync falling edge only
          if (manual && sync_fall) begin
            st_d = HO_HOLD;
          // automatic entry on sensed loss of lock
          end else if (!manual && !sensed_ld) begin
            st_d = HO_HOLD;
          end
        end
        HO_REARM: begin
          if (manual && sync_fall) begin
            st_d = HO_HOLD;
          // relock and charged pin before re-arming
          end else if (digital_lock_flag && sensed_ld) begin
            st_d = HO_ARMED;
          end
        end
        HO_HOLD: begin
          // exit on reference edge; in manual mode only once sync is high
          // a switchover loss ends at the next edge
          if (ref_rise && (!manual || sync_hi)) begin
            st_d = HO_REARM;
            // B counter reset with the exit
            bres_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= HO_REARM;
    end else begin
      st_q <= st_d;
    end
  end

  // charge pump high impedance throughout holdover
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cp_hiz_q <= 1'b0;
      bres_q <= 1'b0;
    end else begin
      cp_hiz_q <= st_d == HO_HOLD;
      bres_q <= bres_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lock_detect_pin_o = ld_o_q;
  assign lock_detect_pin_oe = ld_oe_q;
  assign status_pin = status_q;
  assign reference_monitor_pin = reference_monitor_pin_q;
  assign cp_hiz = cp_hiz_q;
  assign b_counter_reset = bres_q;

  chk_hold_hiz: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_q == HO_HOLD) |-> cp_hiz_q)
    else $error("charge pump not high impedance in holdover");

  chk_disable_all: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !hold_en |=> !cp_hiz_q)
    else $error("holdover active while disabled");

  chk_manual_entry: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (hold_en && manual && sync_fall && st_q != HO_HOLD) |=> cp_hiz_q)
    else $error("sync falling edge did not enter holdover");

  chk_exit_on_ref: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(cp_hiz_q) && hold_en |-> $past(ref_rise))
    else $error("holdover left without reference edge");

  chk_sync_low_stays: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (st_q == HO_HOLD && manual && !sync_hi && hold_en) |=> cp_hiz_q)
    else $error("holdover left while sync low");

  chk_bcnt_exit: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(cp_hiz_q) && hold_en |-> b_counter_reset ##1 !b_counter_reset)
    else $error("B counter reset not pulsed on exit");

  chk_auto_entry: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (hold_en && !manual && st_q == HO_ARMED && !sensed_ld) |=> cp_hiz_q)
    else $error("lost lock did not enter holdover");

  chk_cmp_off_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !cmp_en |-> sensed_ld)
    else $error("disabled comparator not sensed high");

  chk_no_reentry: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_q == HO_REARM && !manual && !(digital_lock_flag && sensed_ld)) |=> !cp_hiz_q)
    else $error("holdover re-entered before relock");

  chk_csrc_ground: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (csrc && !digital_lock_flag) |=> (lock_detect_pin_oe && !lock_detect_pin_o))
    else $error("current source pin not grounded on unlock");

  chk_charge_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !digital_lock_flag |=> !charge_done_q)
    else $error("charge indication survived an unlocked cycle");

  chk_charge_time: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(charge_done_q) |-> $past(digital_lock_flag, 1) && $past(digital_lock_flag, 2))
    else $error("charge completed too early");

  chk_ld_lock_sel: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ld_ctrl_q == LD_SEL_DLD) |=> lock_detect_pin_o == $past(digital_lock_flag))
    else $error("lock pin does not follow the lock flag");

  chk_status_cmp_n: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (cp_stat_q[STAT_SEL_LSB +: 6] == PIN_SEL_CMP_N) |=>
    status_pin == !$past(ld_level))
    else $error("status pin not the inverted comparator");

  chk_monitor_cmp: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ({1'b0, mon_ctrl_q} == PIN_SEL_CMP) |=>
    reference_monitor_pin == $past(ld_level))
    else $error("monitor pin not the comparator");

  chk_dld_disabled: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !ld_bus.enable |=> !digital_lock_flag)
    else $error("lock flag set while detector disabled");

  chk_bcnt_only_exit: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    b_counter_reset |-> $fell(cp_hiz_q))
    else $error("B counter reset outside a holdover exit");
endmodule

// ---- tb/pldh_partner.sv ----
// Host-side model driving phase detector pins and the sync pin
module pldh_partner (
  input wire logic clk,
  output logic ref_pfd_in,
  output logic fb_pfd_in,
  output logic sync_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ref_pfd_in = 1'b0;
    fb_pfd_in = 1'b0;
    sync_b = 1'b1;
  end
  // pair spacing beats unlock threshold
  // A gap of per or more sends a lone reference edge
  task automatic pair(input int gap, input int per);
    for (int c = 0; c < per; c++) begin
      ref_pfd_in <= (c < 2);
      fb_pfd_in <= (c >= gap && c < gap + 2);
      @(posedge clk);
    end
  endtask
  task automatic sync_set(input logic v);
    sync_b <= v;
    @(posedge clk);
  endtask
endmodule

// ---- tb/pldh_core_bench.sv ----
// Self-checking bench for the lock-detect and holdover controller
module pldh_core_bench
  import pldh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHG = 4;
  logic ref_clk;
  logic rst_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic [9:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, rd, rv;
  logic pready, pslverr, ld_o, ld_oe, stat_p, mon_p, cp_hiz, b_rst;
  logic ref_p, fb_p, sync_b, err, w;
  logic prev_hiz = 1'b0;
  logic [1:0] ab;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n_hold = 0;
  int n_brst = 0;
  int thr, ulk, h0;
  logic [7:0] idx_l[6] = '{IDX_CP_STAT, IDX_LOCK_CFG, IDX_LD_CTRL,
    IDX_MON_CTRL, IDX_HOLD_CFG, IDX_LOCK_STAT};
  logic [31:0] wm[5] = '{32'hFF, 32'hFF, 32'h3F, 32'h1F, 32'hF};
  logic [5:0] ldc[4] = '{6'h00, 6'h01, 6'h04, 6'h3F};
  logic [31:0] ldx[4] = '{32'h1, 32'h3, 32'h3, 32'h0};

  always #2 ref_clk = ~ref_clk;

  pldh_core #(.CHARGE_CYC(CHG)) i_pldh_core (.ref_clk(ref_clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_pfd_in(ref_p), .fb_pfd_in(fb_p),
    .sync_b(sync_b), .lock_detect_pin_o(ld_o),
    .lock_detect_pin_oe(ld_oe), .status_pin(stat_p),
    .reference_monitor_pin(mon_p), .cp_hiz(cp_hiz),
    .b_counter_reset(b_rst));
  pldh_partner i_pldh_partner (.clk(ref_clk), .ref_pfd_in(ref_p),
    .fb_pfd_in(fb_p), .sync_b(sync_b));

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic wn, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wn;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    chk(pready, 1, "no ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [31:0] m,
                     input logic [31:0] e, input string s);
    apb(1'b0, {i, 2'b00}, '0);
    chk(rd & m, e, s);
  endtask

  task automatic pairs(input int n, input int g);
    repeat (n) i_pldh_partner.pair(g, 24);
  endtask

  task automatic wait_hiz(input logic v, input int lim);
    int n;
    n = 0;
    while (cp_hiz !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk(cp_hiz, v, "hiz wait");
  endtask

  function automatic int need(input logic [1:0] c);
    case (c)
      2'd0: return int'(LOCK_CNT_C0);
      2'd1: return int'(LOCK_CNT_C1);
      2'd2: return int'(LOCK_CNT_C2);
      default: return int'(LOCK_CNT_C3);
    endcase
  endfunction

  function automatic int lthr(input logic win, input logic [1:0] a);
    return int'(win ? LOCK_WIN_LO_CYC : LOCK_WIN_HI_CYC) +
      int'(a) * int'(ABP_STEP_CYC);
  endfunction

  function automatic logic [31:0] pin_exp(input int s, input logic cmp);
    case (s)
      1: return 32'h3;
      2: return {30'h0, cmp, cmp};
      3: return {30'h0, !cmp, !cmp};
      default: return 32'h0;
    endcase
  endfunction

  // Exit edge and B counter reset must coincide
  always @(posedge ref_clk) begin
    cyc++;
    if (rst_b && (b_rst !== 1'b0 || (prev_hiz && cp_hiz !== 1'b1)))
      chk(b_rst, prev_hiz & ~cp_hiz, "b reset");
    if (rst_b && b_rst === 1'b1)
      n_brst++;
    if (rst_b && !prev_hiz && cp_hiz === 1'b1)
      n_hold++;
    prev_hiz = cp_hiz;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    ref_clk = 1'b0;
    rst_b <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= '0;
    pwdata <= '0;
    void'($urandom(32'h6a924698));
    tick(8);
    chk({ld_o, ld_oe, stat_p, mon_p, cp_hiz}, 32'h8, "pins");
    rst_b <= 1'b1;
    for (int k = 0; k < 6; k++)
      rdc(idx_l[k], (k == 5) ? 32'h9 : 32'hFFFF_FFFF, 0, "rst");
    for (int k = 0; k < 5; k++) begin
      rv = $urandom;
      rdc(idx_l[k], 32'hFFFF_FFFF, 0, "pre");
      wr(idx_l[k], rv);
      rdc(idx_l[k], 32'hFFFF_FFFF, rv & wm[k], "rw");
      wr(idx_l[k], 0);
    end
    apb(1'b0, 10'h084, '0);
    chk(err, 1, "unmapped err");
    chk(rd, 0, "unmapped data");
    apb(1'b1, {IDX_LD_CTRL, 2'b10}, 32'h3F);
    chk(err, 1, "unaligned err");
    rdc(IDX_LD_CTRL, 32'hFFFF_FFFF, 0, "unaligned");
    wr(IDX_LOCK_STAT, 32'hFFFF_FFFF);
    rdc(IDX_LOCK_STAT, 32'h9, 0, "read only");
    $display("test registers done");
    ab = 2'($urandom_range(3));
    w = 1'($urandom_range(1));
    thr = lthr(w, ab);
    ulk = thr + int'(UNLOCK_MARGIN_CYC);
    wr(IDX_CP_STAT, {30'h0, ab});
    wr(IDX_LOCK_CFG, {27'h0, w, 4'h0});
    pairs(3, $urandom_range(thr - 1, 0));
    pairs(1, thr);
    pairs(need(0) - 1, $urandom_range(thr - 1, 0));
    rdc(IDX_LOCK_STAT, 1, 0, "run broken");
    pairs(1, thr - 1);
    rdc(IDX_LOCK_STAT, 1, 1, "locked");
    pairs(1, ulk);
    rdc(IDX_LOCK_STAT, 1, 1, "hysteresis");
    pairs(1, ulk + 1);
    rdc(IDX_LOCK_STAT, 1, 0, "unlock");
    $display("test window done");
    thr = lthr(1'b0, ab);
    ulk = thr + int'(UNLOCK_MARGIN_CYC);
    for (int c = 1; c < 4; c++) begin
      wr(IDX_LOCK_CFG, 32'(c) << LC_CNT_LSB);
      pairs(need(2'(c)) - 1, 0);
      rdc(IDX_LOCK_STAT, 1, 0, "count early");
      pairs(1, 0);
      rdc(IDX_LOCK_STAT, 1, 1, "count met");
      pairs(1, ulk + 1);
    end
    wr(IDX_LOCK_CFG, 32'h1 << LC_DIS_BIT);
    pairs(6, 0);
    rdc(IDX_LOCK_STAT, 1, 0, "disabled");
    wr(IDX_LOCK_CFG, 0);
    pairs(5, 0);
    $display("test counts done");
    for (int k = 0; k < 4; k++) begin
      wr(IDX_LD_CTRL, {26'h0, ldc[k]});
      tick(3);
      chk({ld_o & ld_oe, ld_oe}, ldx[k], "lock pin");
    end
    for (int k = 0; k < 8; k++) begin
      wr(IDX_LD_CTRL, (k < 4) ? 32'h4 : 32'h0);
      wr(IDX_CP_STAT, {24'h0, 6'(k % 4), ab});
      wr(IDX_MON_CTRL, 32'(k % 4));
      tick(CHG + 4);
      chk({stat_p, mon_p}, pin_exp(k % 4, k < 4), "mux");
    end
    wr(IDX_LD_CTRL, 32'h4);
    wr(IDX_CP_STAT, {24'h0, 6'h2, ab});
    tick(CHG + 4);
    pairs(1, ulk + 1);
    chk({ld_o, ld_oe, stat_p}, 32'h2, "discharge");
    $display("test pins done");
    wr(IDX_HOLD_CFG, 32'h3);
    i_pldh_partner.sync_set(1'b0);
    tick(12);
    chk(cp_hiz, 0, "half enable a");
    i_pldh_partner.sync_set(1'b1);
    wr(IDX_HOLD_CFG, 32'h6);
    i_pldh_partner.sync_set(1'b0);
    tick(12);
    chk(cp_hiz, 0, "half enable b");
    wr(IDX_HOLD_CFG, 32'h7);
    tick(12);
    chk(cp_hiz, 0, "level only");
    i_pldh_partner.sync_set(1'b1);
    tick(4);
    i_pldh_partner.sync_set(1'b0);
    wait_hiz(1'b1, 6);
    rdc(IDX_LOCK_STAT, 32'h8, 32'h8, "hiz flag");
    pairs(1, 99);
    chk(cp_hiz, 1, "sync still low");
    i_pldh_partner.sync_set(1'b1);
    tick(30);
    chk(cp_hiz, 1, "no reference");
    i_pldh_partner.pair(99, 40);
    chk(cp_hiz, 0, "manual exit");
    chk(n_brst, 1, "b reset count");
    wr(IDX_HOLD_CFG, 0);
    $display("test manual done");
    // current source pin for automatic holdover
    pairs(5, 0);
    tick(CHG + 4);
    wr(IDX_HOLD_CFG, 32'hD);
    i_pldh_partner.sync_set(1'b0);
    tick(12);
    chk(cp_hiz, 0, "auto ignores sync");
    i_pldh_partner.sync_set(1'b1);
    h0 = n_hold;
    pairs(1, ulk + 1);
    chk(cp_hiz, 1, "auto entry");
    pairs(1, 99);
    chk(cp_hiz, 0, "auto exit");
    pairs(3, ulk + 1);
    chk(n_hold, h0 + 1, "no reentry");
    pairs(5, 0);
    tick(CHG + 4);
    pairs(1, ulk + 1);
    chk(n_hold, h0 + 2, "reentry");
    pairs(1, 99);
    wr(IDX_HOLD_CFG, 32'h5);
    pairs(5, 0);
    tick(CHG + 4);
    pairs(1, ulk + 1);
    chk(n_hold, h0 + 2, "sensed high");
    $display("test auto done");
    results();
  end
endmodule
